// file: core/sld_top.sv
// Purpose: Register file, display RAM and auto-start for a segment LCD driver
// Assumes: AXI4-Lite master keeps one write and one read in flight at most
// Notes:   Display RAM has no reset; contents are undefined until written
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1 - Duty field picks static to quarter duty
// R2 - Replicate spare commons unless quarter duty
// R3 - Select field chooses active segment pins
// R4 - Config bits 7:6, 5, 3:0 read/write
// R5 - Sixteen-byte display RAM, read/write, no reset
// R6 - RAM write while running starts display, except bytes 8-15 at quarter duty
// R7 - Software configures before writing display data
// R8 - Low nibble odd segment, high nibble even
// R9 - One bit lights element, zero darkens
// R10 - Blank control clear forces blank segments
// R11 - Run clear stops, supply off, registers kept
module sld_top
  import sld_pkg::*;
#(
  parameter int P_STEP_CYC = STEP_CYC
) (
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_sys_rst,
  // AXI4-Lite write address/data/response
  input  wire logic [ADDR_W-1:0] i_axi_awaddr,
  input  wire logic              i_axi_awvalid,
  output logic                   o_axi_awready,
  input  wire logic [31:0]       i_axi_wdata,
  input  wire logic [3:0]        i_axi_wstrb,
  input  wire logic              i_axi_wvalid,
  output logic                   o_axi_wready,
  output logic [1:0]             o_axi_bresp,
  output logic                   o_axi_bvalid,
  input  wire logic              i_axi_bready,
  // AXI4-Lite read address/data
  input  wire logic [ADDR_W-1:0] i_axi_araddr,
  input  wire logic              i_axi_arvalid,
  output logic                   o_axi_arready,
  output logic [31:0]            o_axi_rdata,
  output logic [1:0]             o_axi_rresp,
  output logic                   o_axi_rvalid,
  input  wire logic              i_axi_rready,
  // Panel drive
  output logic [N_COM-1:0]       o_common,
  output logic [N_SEG-1:0]       o_segment,
  output logic [N_SEG-1:0]       o_seg_enable,
  output logic                   o_drive_supply
);
  logic [7:0]  ram [RAM_BYTES];  // Display RAM, deliberately unreset
  logic [7:0]  cfg;              // lcd_pin_duty_config
  logic [7:0]  ctrl;             // Run / blank_control / drive_supply_on
  logic        started;          // Image shown since a RAM write
  logic        aw_got;           // Write address held
  logic [15:0] aw_idx;
  logic        w_got;            // Write data held
  logic [7:0]  w_byte;
  logic        w_lane;           // Low byte lane enabled
  logic        next_aw_got;
  logic [15:0] next_aw_idx;
  logic        next_w_got;
  logic [7:0]  next_w_byte;
  logic        next_w_lane;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [1:0]  next_rresp;
  logic [31:0] next_rdata;
  logic [7:0]  next_cfg;
  logic [7:0]  next_ctrl;
  logic        next_started;
  logic        do_wr;            // Both halves present, commit now
  logic        ram_wr;           // Commit targets display RAM
  sld_hit_e    wr_hit;
  sld_hit_e    rd_hit;
  sld_link_if  lnk ();

  // Handshake readies: one write and one read outstanding
  assign o_axi_awready = !aw_got && !o_axi_bvalid;
  assign o_axi_wready  = !w_got && !o_axi_bvalid;
  assign o_axi_arready = !o_axi_rvalid;
  assign wr_hit        = sld_decode(aw_idx);
  assign rd_hit        = sld_decode(i_axi_araddr[ADDR_W-1:2]);
  assign do_wr         = aw_got && w_got && !o_axi_bvalid;
  assign ram_wr        = do_wr && w_lane && wr_hit == HIT_RAM;

  // Write channel: address and data accepted in either order
  always_comb begin
    next_aw_got = aw_got;
    next_aw_idx = aw_idx;
    next_w_got  = w_got;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bvalid = o_axi_bvalid;
    next_bresp  = o_axi_bresp;
    next_cfg    = cfg;
    next_ctrl   = ctrl;
    if (i_axi_awvalid && o_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_idx = i_axi_awaddr[ADDR_W-1:2];
    end
    if (i_axi_wvalid && o_axi_wready) begin
      next_w_got  = 1'b1;
      next_w_byte = i_axi_wdata[7:0];
      next_w_lane = i_axi_wstrb[0];
    end
    if (do_wr) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = (wr_hit == HIT_NONE) ? RESP_SLVERR : RESP_OKAY;
      // Field bits kept, bit 4 reserved [R4]
      if (w_lane && wr_hit == HIT_CFG) begin
        next_cfg = w_byte & CFG_MASK;
      end
      if (w_lane && wr_hit == HIT_CTRL) begin
        next_ctrl = w_byte & CTRL_MASK;
      end
    end else if (o_axi_bvalid && i_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Auto-start: writing the duty's RAM while running shows the image [R6]
  always_comb begin
    next_started = started;
    if (!ctrl[CTRL_RUN]) begin
      // Stopping ends the display; settings stay put [R11]
      next_started = 1'b0;
    end else if (ram_wr && (cfg[7:6] != DUTY_QUARTER || !aw_idx[3])) begin
      next_started = 1'b1;
    end
  end

  // Read channel: data one cycle after the address is taken
  always_comb begin
    next_rvalid = o_axi_rvalid;
    next_rresp  = o_axi_rresp;
    next_rdata  = o_axi_rdata;
    if (i_axi_arvalid && o_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = (rd_hit == HIT_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (rd_hit)
        HIT_CFG:  next_rdata = {24'h000000, cfg};
        HIT_CTRL: next_rdata = {24'h000000, ctrl};
        HIT_RAM:  next_rdata = {24'h000000, ram[i_axi_araddr[5:2]]};  // [R5]
        default:  next_rdata = 32'h00000000;
      endcase
    end else if (o_axi_rvalid && i_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      aw_got       <= 1'b0;
      aw_idx       <= '0;
      w_got        <= 1'b0;
      w_byte       <= '0;
      w_lane       <= 1'b0;
      o_axi_bvalid <= 1'b0;
      o_axi_bresp  <= RESP_OKAY;
      o_axi_rvalid <= 1'b0;
      o_axi_rresp  <= RESP_OKAY;
      o_axi_rdata  <= '0;
      cfg          <= CFG_RST;
      ctrl         <= CTRL_RST;
      started      <= 1'b0;
    end else begin
      aw_got       <= next_aw_got;
      aw_idx       <= next_aw_idx;
      w_got        <= next_w_got;
      w_byte       <= next_w_byte;
      w_lane       <= next_w_lane;
      o_axi_bvalid <= next_bvalid;
      o_axi_bresp  <= next_bresp;
      o_axi_rvalid <= next_rvalid;
      o_axi_rresp  <= next_rresp;
      o_axi_rdata  <= next_rdata;
      cfg          <= next_cfg;
      ctrl         <= next_ctrl;
      started      <= next_started;
    end
  end

  // Display RAM: no reset, so the image is undefined until written [R5]
  always_ff @(posedge i_ref_clk) begin
    if (ram_wr) begin
      ram[aw_idx[3:0]] <= w_byte;
    end
  end

  // Hand settings and image to the scanner
  assign lnk.duty      = cfg[CFG_DUTY_LSB +: 2];                          // [R1]
  assign lnk.replicate = cfg[CFG_REPL];                                   // [R2]
  assign lnk.seg_sel   = cfg[CFG_SEG_LSB +: 4];                           // [R3]
  assign lnk.run       = ctrl[CTRL_RUN];
  assign lnk.supply    = ctrl[CTRL_SUPPLY];
  assign lnk.show      = ctrl[CTRL_RUN] && ctrl[CTRL_SHOW] && started;    // [R10]
  for (genvar b = 0; b < RAM_BYTES; b++) begin : g_img
    assign lnk.img[b*8 +: 8] = ram[b];
  end

  sld_scan #(
    .P_STEP_CYC (P_STEP_CYC)
  ) u_scan (
    .i_ref_clk      (i_ref_clk),
    .i_sys_rst      (i_sys_rst),
    .lnk            (lnk.scan),
    .o_common       (o_common),
    .o_segment      (o_segment),
    .o_seg_enable   (o_seg_enable),
    .o_drive_supply (o_drive_supply)
  );

  chk_cfg_write : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R4]
    do_wr && w_lane && wr_hit == HIT_CFG |=> cfg == ($past(w_byte) & 8'hEF))
    else $error("config write not stored with its fields");
  chk_ram_store : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R5]
    ram_wr |=> ram[$past(aw_idx[3:0])] == $past(w_byte))
    else $error("display RAM write lost");
  chk_auto_start : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R6]
    ram_wr && ctrl[CTRL_RUN] && !aw_idx[3] |=> started)
    else $error("RAM write while running did not start display");
  chk_seg_select : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R3]
    ctrl[CTRL_RUN] && cfg[3:0] == 4'h4 |=> o_seg_enable == 16'hFFFF)
    else $error("select code 4 must enable sixteen segments");
  chk_stop_supply : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R11]
    !ctrl[CTRL_RUN] |=> !o_drive_supply && o_common == 4'h0)
    else $error("stopped controller must drop supply and commons");
  chk_stop_retain : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R11]
    $fell(ctrl[CTRL_RUN]) |-> cfg == $past(cfg))
    else $error("stopping must retain configuration");
  chk_lit_bit : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R9]
    o_segment[0] |-> $past(lnk.show) && $past(ram[0][3:0]) != 4'h0)
    else $error("lit segment without a set RAM bit");
  cov_cfg_write : cover property (@(posedge i_ref_clk) do_wr && wr_hit == HIT_CFG);
  cov_start : cover property (@(posedge i_ref_clk) !started ##1 started);
  cov_stop : cover property (@(posedge i_ref_clk) $fell(ctrl[CTRL_RUN]));
  cov_unmapped : cover property (@(posedge i_ref_clk) o_axi_bvalid && o_axi_bresp == RESP_SLVERR);
endmodule
`default_nettype wire

// file: core/sld_pkg.sv
// Purpose: Shared constants, types and decoders for the segment LCD duty/RAM block
// Assumes: Registers sit at word index * 4 on a 32-bit AXI4-Lite bus
// Notes:   Narrow registers live in the low byte; upper bits read as zero
`default_nettype none
package sld_pkg;
  // Bus geometry
  localparam int          ADDR_W        = 18;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // Register word indices (byte address = index * 4)
  localparam logic [15:0] IDX_CFG       = 16'hFFA0;
  localparam logic [15:0] IDX_CTRL      = 16'hFFA1;
  localparam logic [15:0] IDX_RAM_FIRST = 16'hF370;
  localparam logic [15:0] IDX_RAM_LAST  = 16'hF37F;
  // Port-control register layout
  localparam logic [7:0]  CFG_RST       = 8'h00;
  localparam logic [7:0]  CFG_MASK      = 8'hEF;
  localparam int          CFG_DUTY_LSB  = 6;
  localparam int          CFG_REPL      = 5;
  localparam int          CFG_SEG_LSB   = 0;
  // Run/blank/supply control register layout
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  CTRL_MASK     = 8'h70;
  localparam int          CTRL_SUPPLY   = 6;
  localparam int          CTRL_RUN      = 5;
  localparam int          CTRL_SHOW     = 4;
  // Panel geometry
  localparam int          N_COM         = 4;
  localparam int          N_SEG         = 16;
  localparam int          RAM_BYTES     = 16;
  localparam logic [1:0]  DUTY_QUARTER  = 2'h3;
  localparam logic [1:0]  DUTY_STATIC   = 2'h0;
  // Scan timing: one common phase lasts a quarter of a 64 Hz frame
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          FRAME_HZ      = 64;
  localparam int          STEP_CYC      = CLK_HZ / (FRAME_HZ * N_COM);

  // Address decode result
  typedef enum logic [1:0] {
    HIT_NONE = 2'b00,
    HIT_CFG  = 2'b01,
    HIT_CTRL = 2'b10,
    HIT_RAM  = 2'b11
  } sld_hit_e;

  // Classify a word index
  function automatic sld_hit_e sld_decode(input logic [15:0] idx);
    if (idx == IDX_CFG) begin
      return HIT_CFG;
    end else if (idx == IDX_CTRL) begin
      return HIT_CTRL;
    end else if (idx >= IDX_RAM_FIRST && idx <= IDX_RAM_LAST) begin
      return HIT_RAM;
    end
    return HIT_NONE;
  endfunction

  // Segment pins enabled: four per step of the select code, capped at the pin count
  function automatic logic [N_SEG-1:0] sld_seg_mask(input logic [3:0] sel);
    logic [N_SEG-1:0] m;
    m = '0;
    for (int s = 0; s < N_SEG; s++) begin
      m[s] = (s < 4 * int'(sel));
    end
    return m;
  endfunction
endpackage
`default_nettype wire

// file: core/sld_link_if.sv
// Purpose: Carries settings and the display image from the register side to the scanner
// Assumes: Single clock; all signals are flops of the register side, except show, which is an AND of three of them
// Notes:   Image bit (byte * 8 + bit) mirrors display RAM
`timescale 1ns/100ps
`default_nettype none
interface sld_link_if;
  logic [1:0]   duty;       // Duty select
  logic         replicate;  // Common replication
  logic [3:0]   seg_sel;    // Segment-driver select
  logic         run;        // Controller running
  logic         supply;     // Drive supply request
  logic         show;       // Show RAM image (else blank)
  logic [127:0] img;        // Flattened display RAM
  modport ctrl (output duty, replicate, seg_sel, run, supply, show, img);
  modport scan (input duty, replicate, seg_sel, run, supply, show, img);
endinterface
`default_nettype wire

// file: core/sld_scan.sv
// Purpose: Steps through the commons and drives common/segment outputs
// Assumes: Settings stable while scanning; outputs are digital phase levels
// Notes:   Analog drive levels are produced outside this block
`timescale 1ns/100ps
`default_nettype none
module sld_scan
  import sld_pkg::*;
#(
  parameter int P_STEP_CYC = STEP_CYC
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  // Settings from register side
  sld_link_if.scan              lnk,
  // Panel drive
  output logic [N_COM-1:0]      o_common,
  output logic [N_SEG-1:0]      o_segment,
  output logic [N_SEG-1:0]      o_seg_enable,
  output logic                  o_drive_supply
);
  logic [23:0]      step_cnt;       // Cycles within a phase
  logic [1:0]       phase;          // Current common
  logic [1:0]       act_phase;      // Phase, or common 1 when past the chosen duty
  logic [23:0]      next_step_cnt;
  logic [1:0]       next_phase;
  logic [N_COM-1:0] next_common;
  logic [N_SEG-1:0] next_segment;

  // Cutting the duty mid-scan can leave the phase past the last used common;
  // treat it as common 1 at once so no cycle drives a dark or wrong common
  assign act_phase = (phase > lnk.duty) ? 2'h0 : phase;

  // Phase sequencing; halted scanner parks on common 1
  always_comb begin
    next_step_cnt = step_cnt + 24'h000001;
    next_phase    = act_phase;
    if (!lnk.run) begin
      next_step_cnt = '0;
      next_phase    = '0;
    end else if (step_cnt >= 24'(P_STEP_CYC - 1)) begin
      next_step_cnt = '0;
      // Wrap after the last common the duty uses [R1]
      next_phase    = (act_phase >= lnk.duty) ? 2'h0 : act_phase + 2'h1;
    end
  end

  // Common pins: used ones follow the phase, spares copy when asked [R1] [R2]
  always_comb begin
    for (int i = 0; i < N_COM; i++) begin
      if (2'(i) <= lnk.duty) begin
        next_common[i] = lnk.run && (2'(i) == act_phase);
      end else begin
        // At quarter duty no pin is spare, so replication cannot apply
        next_common[i] = lnk.run && lnk.replicate && (2'(i % (int'(lnk.duty) + 1)) == act_phase);
      end
    end
  end

  // Segment pins: odd segment in low nibble, even in high nibble [R8]
  always_comb begin
    for (int s = 0; s < N_SEG; s++) begin
      // A set bit lights the element, blank forces all off [R9] [R10]
      next_segment[s] = lnk.show && lnk.img[(s / 2) * 8 + (s % 2) * 4 + int'(act_phase)];
    end
  end

  // Register everything that leaves the block
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      step_cnt       <= '0;
      phase          <= '0;
      o_common       <= '0;
      o_segment      <= '0;
      o_seg_enable   <= '0;
      o_drive_supply <= 1'b0;
    end else begin
      step_cnt       <= next_step_cnt;
      phase          <= next_phase;
      o_common       <= next_common;
      o_segment      <= next_segment;
      o_seg_enable   <= lnk.run ? sld_seg_mask(lnk.seg_sel) : '0;  // [R3]
      o_drive_supply <= lnk.run && lnk.supply;                   // [R11]
    end
  end

  chk_quarter_onehot : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R1]
    lnk.run && lnk.duty == DUTY_QUARTER |=> $onehot(o_common))
    else $error("quarter duty must drive exactly one common");
  chk_static_replicate : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R2]
    lnk.run && lnk.duty == DUTY_STATIC && lnk.replicate |=> o_common == 4'hF)
    else $error("static replication must drive all commons");
  chk_seg_even_map : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R8]
    lnk.show |=> o_segment[1] == $past(lnk.img[4 + int'(act_phase)]))
    else $error("second segment must come from the high nibble");
  chk_blank_dark : assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R10]
    !lnk.show |=> o_segment == '0)
    else $error("segments must be dark while blanked");
  cov_phase_wrap : cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    phase == 2'h3 ##1 phase == 2'h0);
endmodule
`default_nettype wire

// file: tb/sld_panel_model.sv
// Purpose: Passive glass model that records which elements were driven on
// Assumes: One common active at a time; segment pin counts only when enabled
// Notes:   A lit element stays recorded until reset, so blanking shows as no new lights
`timescale 1ns/100ps
`default_nettype none
module sld_panel_model (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  // Panel pins
  input  wire logic [3:0]  i_common,
  input  wire logic [15:0] i_segment,
  input  wire logic [15:0] i_seg_enable,
  // Observed image, row c at bits 16c+15..16c
  output logic      [63:0] o_lit
);
  // Record elements seen on while their common is active
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_lit <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        // Only a lone active common is trusted; overlapping commons would blur rows
        if (i_common == 4'(1 << c)) begin
          o_lit[16*c +: 16] <= o_lit[16*c +: 16] | (i_segment & i_seg_enable);
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the segment LCD duty and display RAM block
// Assumes: Scan step shortened to 4 cycles; registers reached over AXI4-Lite
// Notes:   Random data from a fixed seed; expectations from a shadow RAM copy
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sld_pkg::*;
  // Bench state
  logic               clk     = 1'b0;
  logic               rst     = 1'b1;
  logic [ADDR_W-1:0]  awaddr  = '0;
  logic               awvalid = 1'b0;
  logic [31:0]        wdata   = '0;
  logic [3:0]         wstrb   = 4'hF;
  logic               wvalid  = 1'b0;
  logic               bready  = 1'b0;
  logic [ADDR_W-1:0]  araddr  = '0;
  logic               arvalid = 1'b0;
  logic               rready  = 1'b0;
  logic               awready, wready, bvalid, arready, rvalid, drv_supply;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  logic [3:0]         com;
  logic [15:0]        seg, seg_en;
  logic [63:0]        lit;
  logic [7:0]         ram [16];     // Shadow of display RAM
  logic [3:0]         strb  = 4'hF; // Strobe used by the next write
  logic [7:0]         v;
  int                 seed  = 6885;
  int                 n_fail = 0;
  int                 cmp_count = 0;
  int                 i, c;
  // Clock at 25 MHz
  always #20 clk = ~clk;
  // Device under test
  sld_top #(.P_STEP_CYC(4)) i_sld_top (
    .i_ref_clk(clk), .i_sys_rst(rst),
    .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
    .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
    .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
    .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
    .o_common(com), .o_segment(seg), .o_seg_enable(seg_en), .o_drive_supply(drv_supply));
  // Glass on the far side
  sld_panel_model i_sld_panel_model (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_common(com), .i_segment(seg),
    .i_seg_enable(seg_en), .o_lit(lit));
  // Verdict and end of run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One comparison, four-state exact
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // AXI4-Lite write of one register byte; bready stays high between calls
  task automatic axi_wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge clk);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        b = 1'b1;
        chk("bresp", 64'(bresp), 64'(er));
      end
    end
    // A missing answer ends the run
    if (!b) begin
      n_fail++;
      wrap_up();
    end
  endtask
  // AXI4-Lite read compared with an expected word and response; rready stays high
  task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] ed,
                        input logic [1:0] er);
    logic ar, r;
    ar = 1'b1;
    r = 1'b0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !r; n++) begin
      @(posedge clk);
      if (ar && arready === 1'b1) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        r = 1'b1;
        chk(what, {rresp, rdata}, {er, ed});
      end
    end
    if (!r) begin
      n_fail++;
      wrap_up();
    end
  endtask
  // Expected segment row for common c from the shadow RAM
  function automatic logic [15:0] seg_exp(input int cc);
    logic [15:0] e;
    for (int s = 0; s < 16; s++) e[s] = ram[s/2][(s%2)*4 + cc];
    return e;
  endfunction
  // Enabled segment pins for a select code, four per step
  function automatic logic [15:0] mask_exp(input int sel);
    return (sel >= 4) ? 16'hFFFF : 16'hFFFF >> (16 - 4*sel);
  endfunction
  // Let the scan run a few frames, then compare every glass row
  task automatic panel_chk();
    repeat (40) @(posedge clk);
    for (int r = 0; r < 4; r++) chk("panel row", 64'(lit[16*r +: 16]), 64'(seg_exp(r)));
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("cfg reset", IDX_CFG, 32'(CFG_RST), RESP_OKAY);
    rd_chk("ctrl reset", IDX_CTRL, 32'(CTRL_RST), RESP_OKAY);
    // Config fields, all ones first, then random
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hFF : 8'($random(seed));
      axi_wr(IDX_CFG, v, RESP_OKAY);
      rd_chk("cfg rw", IDX_CFG, 32'(v & CFG_MASK), RESP_OKAY);
    end
    // Whole RAM while stopped, then a write with byte lane 0 off
    for (i = 0; i < 16; i++) begin
      ram[i] = 8'($random(seed));
      axi_wr(IDX_RAM_FIRST + 16'(i), ram[i], RESP_OKAY);
    end
    strb = 4'hE;
    axi_wr(IDX_RAM_LAST, ~ram[15], RESP_OKAY);
    strb = 4'hF;
    for (i = 0; i < 16; i++) rd_chk("ram", IDX_RAM_FIRST + 16'(i), 32'(ram[i]), RESP_OKAY);
    axi_wr(IDX_RAM_LAST + 16'h1, 8'h5A, RESP_SLVERR);
    rd_chk("unmapped", IDX_RAM_LAST + 16'h1, 32'h0, RESP_SLVERR);
    // Settings first, display data after; nothing may light before the data write
    axi_wr(IDX_CFG, 8'hC4, RESP_OKAY);
    axi_wr(IDX_CTRL, 8'h70, RESP_OKAY);
    repeat (20) @(posedge clk);
    chk("lit before start", lit, 64'h0);
    chk("seg enable", 64'(seg_en), 64'h0000_FFFF);
    chk("supply on", 64'(drv_supply), 64'h1);
    ram[0] = 8'hD7;
    axi_wr(IDX_RAM_FIRST, ram[0], RESP_OKAY);
    panel_chk();
    // Blank control clear: scanning goes on with dark segments
    axi_wr(IDX_CTRL, 8'h60, RESP_OKAY);
    repeat (40) begin
      @(negedge clk);
      chk("blank segments", 64'(seg), 64'h0);
    end
    @(posedge clk);
    axi_wr(IDX_CTRL, 8'h70, RESP_OKAY);
    // Every segment select code
    for (i = 0; i < 16; i++) begin
      axi_wr(IDX_CFG, {4'hC, 4'(i)}, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("seg enable", 64'(seg_en), 64'(mask_exp(i)));
    end
    // Every duty with and without replication of spare commons
    for (i = 0; i < 8; i++) begin
      axi_wr(IDX_CFG, {2'(i/2), 1'(i%2), 5'h04}, RESP_OKAY);
      repeat (2) @(posedge clk);
      repeat (16) begin
        @(negedge clk);
        chk("used commons", 64'($onehot(com & 4'(4'hF >> (3 - i/2)))), 64'h1);
        for (c = i/2 + 1; c < 4; c++) begin
          chk("spare common", 64'(com[c]), (i%2) ? 64'(com[c % (i/2 + 1)]) : 64'h0);
        end
      end
      @(posedge clk);
    end
    // Run clear with supply requested: all drive off, contents kept
    axi_wr(IDX_CTRL, 8'h40, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("stopped outputs", 64'({com, seg, seg_en, drv_supply}), 64'h0);
    rd_chk("cfg kept", IDX_CFG, 32'h0000_00E4, RESP_OKAY);
    rd_chk("ctrl kept", IDX_CTRL, 32'h0000_0040, RESP_OKAY);
    rd_chk("ram kept", IDX_RAM_FIRST, 32'(ram[0]), RESP_OKAY);
    // Restart: upper-half data must not start quarter duty, the low half must
    axi_wr(IDX_CTRL, 8'h70, RESP_OKAY);
    axi_wr(IDX_RAM_LAST, 8'hFF, RESP_OKAY);
    repeat (20) @(posedge clk);
    chk("no start upper half", 64'(seg), 64'h0);
    axi_wr(IDX_RAM_FIRST, ram[0], RESP_OKAY);
    repeat (20) @(posedge clk);
    chk("restart commons", 64'($onehot(com)), 64'h1);
    for (c = 0; c < 4; c++) if (com[c]) chk("restart row", 64'(seg), 64'(seg_exp(c)));
    wrap_up();
  end
endmodule
`default_nettype wire
